// ==== pkg/tnc_pkg.sv ====
// shared constants, types and helpers for the transfer node codec
package tnc_pkg;
  typedef enum logic [2:0] {TNC_W8, TNC_W10, TNC_W12, TNC_W14, TNC_W16} tnc_width_t;
  typedef enum logic [2:0] {
    TNC_OP_XENC, TNC_OP_YENC, TNC_OP_TEMP, TNC_OP_XDEC, TNC_OP_YDEC
  } tnc_op_t;
  typedef enum logic [1:0] {TNC_TF_DEFAULT, TNC_TF_HIGH, TNC_TF_SPECIAL} tnc_tf_t;

  localparam int FIELD_W = 12;
  localparam int WORD_W = 16;
  localparam int EXP_MAX_W = 4;
  localparam int TEMP_FRAC = 4;
  localparam int SLOPE_FRAC = 8;
  localparam int PROD_SHIFT = TEMP_FRAC + SLOPE_FRAC;
  localparam logic signed [35:0] PROD_ROUND = 36'sh000000800;
  localparam logic [15:0] LOW_CLAMP = 16'h0001;
  localparam logic [15:0] INIT_CODE = 16'h0000;
  localparam logic [16:0] RESERVED_TOP = 17'h00008;
  localparam logic [16:0] DEF_Y2_GAP = 17'h00007;
  localparam logic [15:0] DEF_Y1_W8 = 16'h000C;
  localparam logic [15:0] DEF_Y1_W10 = 16'h0030;
  localparam logic [15:0] DEF_Y1_W12 = 16'h00C1;
  localparam logic [15:0] DEF_Y1_W14 = 16'h0302;
  localparam logic [15:0] DEF_Y1_W16 = 16'h0C08;
  localparam logic [7:0] SLOPE_DEF_W12 = 8'h08;
  localparam logic [7:0] SLOPE_DEF_W10 = 8'h04;
  localparam logic [7:0] SLOPE_DEF_W8 = 8'h01;
  localparam logic [7:0] SLOPE_HIGH = 8'h03;
  localparam logic [11:0] OFFS_200K = 12'h0C8;
  localparam logic [11:0] OFFS_220K = 12'h0DC;

  function automatic logic [4:0] tnc_bits(tnc_width_t w);
    case (w)
      TNC_W8: tnc_bits = 5'h08;
      TNC_W10: tnc_bits = 5'h0A;
      TNC_W12: tnc_bits = 5'h0C;
      TNC_W14: tnc_bits = 5'h0E;
      default: tnc_bits = 5'h10;
    endcase
  endfunction : tnc_bits

  function automatic logic [15:0] tnc_high_clamp(tnc_width_t w);
    logic [16:0] full;
    full = (17'h00001 << tnc_bits(w)) - RESERVED_TOP;
    tnc_high_clamp = full[15:0];
  endfunction : tnc_high_clamp

  function automatic logic [15:0] tnc_def_y1(tnc_width_t w);
    case (w)
      TNC_W8: tnc_def_y1 = DEF_Y1_W8;
      TNC_W10: tnc_def_y1 = DEF_Y1_W10;
      TNC_W12: tnc_def_y1 = DEF_Y1_W12;
      TNC_W14: tnc_def_y1 = DEF_Y1_W14;
      default: tnc_def_y1 = DEF_Y1_W16;
    endcase
  endfunction : tnc_def_y1

  function automatic logic [15:0] tnc_def_y2(tnc_width_t w);
    logic [16:0] full;
    full = (17'h00001 << tnc_bits(w)) - DEF_Y2_GAP - {1'b0, tnc_def_y1(w)};
    tnc_def_y2 = full[15:0];
  endfunction : tnc_def_y2
endpackage : tnc_pkg

// ==== pkg/tnc_temp_if.sv ====
// link between the codec top and its temperature word encoder
`timescale 1ns/1ps
interface tnc_temp_if;
  import tnc_pkg::*;
  tnc_tf_t tf_mode;
  tnc_width_t width;
  logic [15:0] temp_q4;
  logic [15:0] spec_slope;
  logic [11:0] spec_x1;
  logic [15:0] spec_y1;
  logic [15:0] word;
  logic clamped;
  logic bad;
  modport enc (
    input tf_mode, width, temp_q4, spec_slope, spec_x1, spec_y1,
    output word, clamped, bad
  );
  modport ctl (
    output tf_mode, width, temp_q4, spec_slope, spec_x1, spec_y1,
    input word, clamped, bad
  );
endinterface : tnc_temp_if

// ==== hw/tnc_temp_enc.sv ====
// combinational temperature word encoder for the three transfer functions
`timescale 1ns/1ps
module tnc_temp_enc (
  tnc_temp_if.enc t
);
  import tnc_pkg::*;

  logic [15:0] slope_sel;
  logic [11:0] x_sel;
  logic [15:0] y_sel;
  logic [15:0] hi;
  logic signed [17:0] diff;
  logic signed [35:0] prod;
  logic signed [35:0] val;

  // default and high-temperature curves reuse the special datapath with y1 = 0
  always_comb begin
    slope_sel = 16'h0000;
    x_sel = OFFS_200K;
    y_sel = 16'h0000;
    t.bad = 1'b0;
    hi = tnc_high_clamp(t.width);
    case (t.tf_mode)
      TNC_TF_DEFAULT: begin
        case (t.width)
          TNC_W12: slope_sel = {SLOPE_DEF_W12, 8'h00};
          TNC_W10: begin
            slope_sel = {SLOPE_DEF_W10, 8'h00};
            x_sel = OFFS_220K;
          end
          TNC_W8: begin
            slope_sel = {SLOPE_DEF_W8, 8'h00};
            x_sel = OFFS_220K;
          end
          default: t.bad = 1'b1;
        endcase
      end
      TNC_TF_HIGH: begin
        slope_sel = {SLOPE_HIGH, 8'h00};
        t.bad = (t.width != TNC_W12);
      end
      TNC_TF_SPECIAL: begin
        slope_sel = t.spec_slope;
        x_sel = t.spec_x1;
        y_sel = t.spec_y1;
      end
      default: t.bad = 1'b1;
    endcase
    // slope times kelvin minus offset, rounded half up
    diff = $signed({2'b00, t.temp_q4}) - $signed({2'b00, x_sel, 4'h0});
    prod = diff * $signed({1'b0, slope_sel});
    val = ((prod + PROD_ROUND) >>> PROD_SHIFT) + $signed({20'h00000, y_sel});
    t.clamped = 1'b0;
    if (val < $signed({20'h00000, LOW_CLAMP})) begin
      t.word = LOW_CLAMP;
      t.clamped = 1'b1;
    end else if (val > $signed({20'h00000, hi})) begin
      t.word = hi;
      t.clamped = 1'b1;
    end else begin
      t.word = val[15:0];
    end
  end
endmodule : tnc_temp_enc

// ==== hw/tnc_codec.sv ====
// transfer node and temperature word codec, sensor side
// Overview of operation
// - node coordinates travel as 12-bit encoded values in serial data fields
// - node indices are clamped between one and two to the n minus eight
// - sent indices override defaults; defaults may still be sent explicitly
// - 12-bit channel: index goes into the field unchanged
// - narrower channel: index sits in low field bits, upper bits zero
// - wider channel: top twelve index bits sent, low bits rebuilt as zero
// - physical node packs mantissa above exponent in the field
// - temperature uses default, high-temperature or special linear function
// - word is rounded slope times kelvin minus offset, within clamp range
// - default slopes 8/4/1 with offsets 200/220/220 kelvin
// - high-temperature function is 12-bit only, slope 3, offset 200 K
// - a default-function sensor may cover a narrower span
// - default indices derive from ceiling of 0.047 of the data range
// - zero is initialization, top seven are errors, overrange clamps
`timescale 1ns/1ps
module tnc_codec (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // request
  input wire logic in_valid,
  input tnc_pkg::tnc_op_t op,
  input tnc_pkg::tnc_width_t width,
  input tnc_pkg::tnc_tf_t tf_mode,
  input wire logic node_sel,
  input wire logic use_default_y,
  input wire logic init_active,
  input wire logic [15:0] in_value,
  // physical node parts
  input wire logic [11:0] x_mantissa,
  input wire logic [3:0] x_exponent,
  input wire logic [2:0] exp_width,
  // special temperature curve
  input wire logic [15:0] spec_slope,
  input wire logic [11:0] spec_x1,
  input wire logic [15:0] spec_y1,
  // result
  output logic out_valid,
  output logic [15:0] out_data,
  output logic [3:0] out_exponent,
  output logic out_clamped,
  output logic out_error
);
  import tnc_pkg::*;

  tnc_temp_if tif ();

  logic out_valid_reg, out_valid_next;
  logic [15:0] out_data_reg, out_data_next;
  logic [3:0] out_exponent_reg, out_exponent_next;
  logic out_clamped_reg, out_clamped_next;
  logic out_error_reg, out_error_next;

  logic [EXP_MAX_W-1:0] exp_mask;
  logic ne_bad;
  logic [15:0] hi;
  logic [15:0] y_sel;
  logic [15:0] y_lim;
  logic y_clamp;
  logic [11:0] y_field;
  logic [15:0] y_back;
  logic y_back_bad;
  logic [11:0] x_field;
  logic x_ovf;
  logic [11:0] x_mant_back;
  logic [3:0] x_exp_back;

  tnc_temp_enc u_temp (
    .t(tif)
  );

  assign tif.tf_mode = tf_mode;
  assign tif.width = width;
  assign tif.temp_q4 = in_value;
  assign tif.spec_slope = spec_slope;
  assign tif.spec_x1 = spec_x1;
  assign tif.spec_y1 = spec_y1;

  // exponent field mask, one bit per exponent position
  genvar gi;
  generate
    for (gi = 0; gi < EXP_MAX_W; gi++) begin : g_mask
      assign exp_mask[gi] = (exp_width > 3'(gi));
    end
  endgenerate

  // physical node pack and unpack
  always_comb begin
    ne_bad = (exp_width == 3'h0) || (exp_width > 3'(EXP_MAX_W));
    // mantissa bits that would spill past the field top
    x_ovf = |(x_mantissa & ~(12'hFFF >> exp_width));
    x_field = (x_mantissa << exp_width) | {8'h00, x_exponent & exp_mask};
    x_mant_back = in_value[11:0] >> exp_width;
    x_exp_back = in_value[3:0] & exp_mask;
    // sign-extend the two's complement exponent
    if ((x_exp_back & ~(exp_mask >> 1)) != 4'h0) begin
      x_exp_back = x_exp_back | ~exp_mask;
    end
  end

  // digital node index pack and unpack
  always_comb begin
    hi = tnc_high_clamp(width);
    if (use_default_y) begin
      y_sel = node_sel ? tnc_def_y2(width) : tnc_def_y1(width);
    end else begin
      y_sel = in_value;
    end
    y_clamp = 1'b1;
    if (y_sel < LOW_CLAMP) begin
      y_lim = LOW_CLAMP;
    end else if (y_sel > hi) begin
      y_lim = hi;
    end else begin
      y_lim = y_sel;
      y_clamp = 1'b0;
    end
    // an index that does not fit the channel width is refused, not cut
    y_back_bad = 1'b0;
    case (width)
      TNC_W8: begin
        y_field = {4'h0, y_lim[7:0]};
        y_back = {8'h00, in_value[7:0]};
        y_back_bad = |in_value[11:8];
      end
      TNC_W10: begin
        y_field = {2'b00, y_lim[9:0]};
        y_back = {6'h00, in_value[9:0]};
        y_back_bad = |in_value[11:10];
      end
      TNC_W12: begin
        y_field = y_lim[11:0];
        y_back = {4'h0, in_value[11:0]};
      end
      TNC_W14: begin
        y_field = y_lim[13:2];
        y_back = {2'b00, in_value[11:0], 2'b00};
      end
      default: begin
        y_field = y_lim[15:4];
        y_back = {in_value[11:0], 4'h0};
      end
    endcase
    if (y_back < LOW_CLAMP || y_back > hi) begin
      y_back_bad = 1'b1;
    end
  end

  // result selection
  always_comb begin
    out_valid_next = in_valid;
    out_data_next = out_data_reg;
    out_exponent_next = out_exponent_reg;
    out_clamped_next = out_clamped_reg;
    out_error_next = out_error_reg;
    if (in_valid) begin
      out_exponent_next = 4'h0;
      out_clamped_next = 1'b0;
      out_error_next = 1'b0;
      case (op)
        TNC_OP_XENC: begin
          out_data_next = {4'h0, x_field};
          out_error_next = ne_bad || x_ovf;
        end
        TNC_OP_YENC: begin
          out_data_next = {4'h0, y_field};
          out_clamped_next = y_clamp;
        end
        TNC_OP_TEMP: begin
          // span narrower than the curve needs no special handling
          if (init_active) begin
            out_data_next = INIT_CODE;
          end else begin
            out_data_next = tif.word;
            out_clamped_next = tif.clamped;
            out_error_next = tif.bad;
          end
        end
        TNC_OP_XDEC: begin
          out_data_next = {4'h0, x_mant_back};
          out_exponent_next = x_exp_back;
          out_error_next = ne_bad;
        end
        TNC_OP_YDEC: begin
          out_data_next = y_back;
          out_error_next = y_back_bad;
        end
        default: begin
          out_data_next = 16'h0000;
          out_error_next = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      out_valid_reg <= 1'b0;
      out_data_reg <= 16'h0000;
      out_exponent_reg <= 4'h0;
      out_clamped_reg <= 1'b0;
      out_error_reg <= 1'b0;
    end else begin
      out_valid_reg <= out_valid_next;
      out_data_reg <= out_data_next;
      out_exponent_reg <= out_exponent_next;
      out_clamped_reg <= out_clamped_next;
      out_error_reg <= out_error_next;
    end
  end

  assign out_valid = out_valid_reg;
  assign out_data = out_data_reg;
  assign out_exponent = out_exponent_reg;
  assign out_clamped = out_clamped_reg;
  assign out_error = out_error_reg;
endmodule : tnc_codec

// ==== dv/tnc_codec_asserts.sv ====
// bound port checker for the transfer node codec
`timescale 1ns/1ps
module tnc_codec_asserts
  import tnc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // request
  input wire logic in_valid,
  input tnc_pkg::tnc_op_t op,
  input tnc_pkg::tnc_width_t width,
  input tnc_pkg::tnc_tf_t tf_mode,
  input wire logic use_default_y,
  input wire logic init_active,
  input wire logic [15:0] in_value,
  // result
  input wire logic out_valid,
  input wire logic [15:0] out_data,
  input wire logic out_clamped,
  input wire logic out_error
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  wire t_req = in_valid && op == TNC_OP_TEMP;
  wire y_req = in_valid && op == TNC_OP_YENC && !use_default_y;
  a_valid_next: assert property (in_valid |=> out_valid) else $error("no valid");
  a_valid_quiet: assert property (!in_valid |=> !out_valid) else $error("stray valid");
  a_temp_span: assert property (t_req && width == TNC_W12 && !init_active
    |=> out_data inside {[16'h0001:16'h0FF8]}) else $error("word out of span");
  a_init_zero: assert property (t_req && init_active |=> out_data == 16'h0000)
    else $error("init word not zero");
  a_high_w12: assert property (t_req && tf_mode == TNC_TF_HIGH && width != TNC_W12
    |=> out_error) else $error("high curve off 12 bit");
  a_y12_same: assert property (y_req && width == TNC_W12 && in_value inside {[1:4088]}
    |=> out_data == $past(in_value) && !out_clamped) else $error("index altered");
  a_y16_msb: assert property (y_req && width == TNC_W16 && in_value inside {[1:65528]}
    |=> out_data == {4'h0, $past(in_value[15:4])}) else $error("index misaligned");
  a_y_clamp: assert property (y_req && width == TNC_W12 && in_value > 16'h0FF8
    |=> out_data == 16'h0FF8 && out_clamped) else $error("index not clamped");
  c_temp: cover property (t_req ##1 out_valid);
  c_clamp: cover property (out_valid && out_clamped);
  c_error: cover property (out_valid && out_error);
endmodule : tnc_codec_asserts

bind tnc_codec tnc_codec_asserts u_chk (.sys_clk, .reset, .in_valid, .op, .width, .tf_mode,
  .use_default_y, .init_active, .in_value, .out_valid, .out_data, .out_clamped, .out_error);

// ==== dv/tnc_rx_model.sv ====
// receiver model that rebuilds node indices from message fields
`timescale 1ns/1ps
module tnc_rx_model
  import tnc_pkg::*;
(
  // field as received
  input tnc_pkg::tnc_width_t width,
  input wire logic [11:0] field,
  input wire logic y_sent,
  input wire logic node_sel,
  // rebuilt index and default-curve temperature in 1/16 K
  output logic [15:0] y_index,
  output logic [15:0] temp_q4
);
  int n;
  int y1;
  int s;
  always_comb begin
    n = 8 + 2 * int'(width);
    y1 = int'($ceil(0.047 * ((1 << n) - 8)));
    if (!y_sent) y_index = 16'(node_sel ? (1 << n) - 7 - y1 : y1);
    else if (n > 12) y_index = {field, 4'h0} >> (16 - n);
    else y_index = {4'h0, field};
    // no nodes received, so only the default curve is decoded here
    s = (n == 12) ? 8 : ((n == 10) ? 4 : 1);
    temp_q4 = 16'(int'(field) * (16 / s) + 16 * ((n == 12) ? 200 : 220));
  end
endmodule : tnc_rx_model

// ==== dv/tb_top.sv ====
// self-checking bench for the transfer node codec
`timescale 1ns/1ps
module tb_top;
  import tnc_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic in_valid = 1'b0;
  tnc_op_t op = TNC_OP_TEMP;
  tnc_width_t width = TNC_W12;
  tnc_tf_t tf_mode = TNC_TF_DEFAULT;
  logic node_sel = 1'b0;
  logic use_default_y = 1'b0;
  logic init_active = 1'b0;
  logic y_sent = 1'b1;
  logic [15:0] in_value = 16'h0000;
  logic [11:0] x_mantissa = 12'h000;
  logic [3:0] x_exponent = 4'h0;
  logic [2:0] exp_width = 3'h1;
  logic [15:0] spec_slope = 16'h0000;
  logic [11:0] spec_x1 = 12'h000;
  logic [15:0] spec_y1 = 16'h0000;
  logic out_valid, out_clamped, out_error;
  logic [15:0] out_data, y_index, t_back;
  logic [3:0] out_exponent;
  int err_total = 0;
  int n_compared = 0;

  tnc_codec u_dut (.sys_clk, .reset, .in_valid, .op, .width, .tf_mode, .node_sel,
    .use_default_y, .init_active, .in_value, .x_mantissa, .x_exponent, .exp_width,
    .spec_slope, .spec_x1, .spec_y1, .out_valid, .out_data, .out_exponent, .out_clamped,
    .out_error);
  tnc_rx_model u_rx (.width, .field(out_data[11:0]), .y_sent, .node_sel, .y_index,
    .temp_q4(t_back));

  initial forever #4 sys_clk = ~sys_clk;

  // flags are compared zero-extended to a word
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic req(input tnc_op_t o, input tnc_width_t w, input logic [15:0] v);
    @(posedge sys_clk);
    #1;
    op = o;
    width = w;
    in_value = v;
    in_valid = 1'b1;
    @(posedge sys_clk);
    #1;
    in_valid = 1'b0;
    chk({15'h0, out_valid}, 16'h0001);
  endtask : req

  task automatic t_temp;
    tnc_width_t w[8] = '{TNC_W12, TNC_W10, TNC_W8, TNC_W12, TNC_W12, TNC_W12, TNC_W12, TNC_W12};
    tnc_tf_t f[8] = '{TNC_TF_DEFAULT, TNC_TF_DEFAULT, TNC_TF_DEFAULT, TNC_TF_HIGH,
      TNC_TF_DEFAULT, TNC_TF_DEFAULT, TNC_TF_DEFAULT, TNC_TF_HIGH};
    logic [15:0] v[8] = '{16'h12C0, 16'h12C0, 16'h12C0, 16'h12C0, 16'h0C83, 16'h0640,
      16'h3200, 16'h61AB};
    logic [15:0] e[8] = '{16'h0320, 16'h0140, 16'h0050, 16'h012C, 16'h0002, 16'h0001,
      16'h0FF8, 16'h0FF8};
    logic [7:0] c = 8'h60;
    for (int i = 0; i < 8; i++) begin
      tf_mode = f[i];
      req(TNC_OP_TEMP, w[i], v[i]);
      chk(out_data, e[i]);
      chk({15'h0, out_clamped}, {15'h0, c[i]});
      if (i < 3) chk(t_back, v[i]);
    end
    tf_mode = TNC_TF_SPECIAL;
    spec_slope = 16'h0800;
    spec_x1 = 12'h0E9;
    spec_y1 = 16'h0108;
    req(TNC_OP_TEMP, TNC_W12, 16'h12C0);
    chk(out_data, 16'h0320);
    tf_mode = TNC_TF_HIGH;
    req(TNC_OP_TEMP, TNC_W10, 16'h12C0);
    chk({15'h0, out_error}, 16'h0001);
    tf_mode = TNC_TF_DEFAULT;
    req(TNC_OP_TEMP, TNC_W16, 16'h12C0);
    chk({15'h0, out_error}, 16'h0001);
    init_active = 1'b1;
    req(TNC_OP_TEMP, TNC_W12, 16'h12C0);
    chk(out_data, 16'h0000);
    init_active = 1'b0;
  endtask : t_temp

  task automatic t_node;
    tnc_op_t o[8] = '{TNC_OP_YENC, TNC_OP_YENC, TNC_OP_YENC, TNC_OP_YENC, TNC_OP_YENC,
      TNC_OP_YENC, TNC_OP_YDEC, TNC_OP_YDEC};
    tnc_width_t w[8] = '{TNC_W12, TNC_W10, TNC_W16, TNC_W14, TNC_W12, TNC_W12, TNC_W14, TNC_W16};
    logic [15:0] v[8] = '{16'h0ABC, 16'h0155, 16'h1234, 16'h2345, 16'h0000, 16'h0FFF,
      16'h0123, 16'h0123};
    logic [15:0] e[8] = '{16'h0ABC, 16'h0155, 16'h0123, 16'h08D1, 16'h0001, 16'h0FF8,
      16'h048C, 16'h1230};
    logic [15:0] r[4] = '{16'h0ABC, 16'h0155, 16'h1230, 16'h2344};
    for (int i = 0; i < 8; i++) begin
      req(o[i], w[i], v[i]);
      chk(out_data, e[i]);
      if (i < 4) chk(y_index, r[i]);
    end
    req(TNC_OP_YDEC, TNC_W10, 16'h0800);
    chk({15'h0, out_error}, 16'h0001);
    // defaults come from the receiver model formula, not a table
    use_default_y = 1'b1;
    y_sent = 1'b0;
    for (int s = 0; s < 2; s++) begin
      node_sel = s[0];
      req(TNC_OP_YENC, TNC_W12, 16'h0000);
      chk(out_data, y_index);
    end
    use_default_y = 1'b0;
    y_sent = 1'b1;
  endtask : t_node

  task automatic t_phys;
    x_mantissa = 12'h005;
    x_exponent = 4'h1;
    req(TNC_OP_XENC, TNC_W12, 16'h0000);
    chk(out_data, 16'h000B);
    req(TNC_OP_XDEC, TNC_W12, 16'h000B);
    chk(out_data, 16'h0005);
    chk({12'h000, out_exponent}, 16'h000F);
    exp_width = 3'h4;
    x_mantissa = 12'h0AB;
    x_exponent = 4'h3;
    req(TNC_OP_XENC, TNC_W12, 16'h0000);
    chk(out_data, 16'h0AB3);
    chk({15'h0, out_error}, 16'h0000);
    x_mantissa = 12'h100;
    req(TNC_OP_XENC, TNC_W12, 16'h0000);
    chk({15'h0, out_error}, 16'h0001);
  endtask : t_phys

  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict

  initial begin
    repeat (5) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    chk(out_data, 16'h0000);
    t_temp();
    t_node();
    t_phys();
    give_verdict();
  end

  // twenty-seven requests of two cycles each; ample margin
  initial begin
    #20000;
    err_total++;
    give_verdict();
  end
endmodule : tb_top
